// File: verilog/pmc_top.v
`timescale 1ns/10ps
`include "pmc_consts.vh"
module pmc_top #(
  parameter PAUSE_FAST_CYC = `PMC_PAUSE_FAST_NS / `PMC_CLK_PERIOD_NS,
  parameter PAUSE_SLOW_CYC = `PMC_PAUSE_SLOW_NS / `PMC_CLK_PERIOD_NS,
  parameter SLEEP_FAST_CYC = `PMC_SLEEP_FAST_NS / `PMC_CLK_PERIOD_NS,
  parameter SLEEP_SLOW_CYC = `PMC_SLEEP_SLOW_NS / `PMC_CLK_PERIOD_NS,
  parameter CORE_BASE_DIV  = 2,
  parameter CW             = 16
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        wake_event,
  output reg         core_run_enable,
  output reg         peripheral_run_enable,
  output reg         pll_run_enable,
  output reg         crystal_run_enable,
  output reg         external_interrupt_alive,
  output reg         core_clk_en,
  output reg         external_clock_select,
  output reg         crystal_select,
  output reg         internal_osc_select
);
  localparam [2:0] SEL_NONE   = 3'h0;
  localparam [2:0] SEL_PMODE  = 3'h1;
  localparam [2:0] SEL_PKEY   = 3'h2;
  localparam [2:0] SEL_PLLK1  = 3'h3;
  localparam [2:0] SEL_PLLSRC = 3'h4;
  localparam [2:0] SEL_PLLK2  = 3'h5;
  localparam [2:0] SEL_STAT   = 3'h6;

  // One-hot state of the PLL key sequence
  localparam [2:0] SEQ_IDLE  = 3'h1;
  localparam [2:0] SEQ_KEYED = 3'h2;
  localparam [2:0] SEQ_HELD  = 3'h4;

  // Register address decode, shared by write and read paths
  function [2:0] reg_sel;
    input [31:0] a;
    begin
      case ({a[31:2], 2'h0})
        `PMC_ADDR_POWER_MODE: reg_sel = SEL_PMODE;
        `PMC_ADDR_POWER_KEY:  reg_sel = SEL_PKEY;
        `PMC_ADDR_PLL_KEY1:   reg_sel = SEL_PLLK1;
        `PMC_ADDR_PLL_SOURCE: reg_sel = SEL_PLLSRC;
        `PMC_ADDR_PLL_KEY2:   reg_sel = SEL_PLLK2;
        `PMC_ADDR_STATUS:     reg_sel = SEL_STAT;
        default:              reg_sel = SEL_NONE;
      endcase
    end
  endfunction

  // Wake wait interpolated linearly between the two divider extremes
  function [CW-1:0] wake_cycles;
    input       slow_class;
    input [2:0] div;
    reg   [31:0] fast;
    reg   [31:0] slow;
    reg   [31:0] t;
    begin
      fast = slow_class ? SLEEP_FAST_CYC : PAUSE_FAST_CYC;
      slow = slow_class ? SLEEP_SLOW_CYC : PAUSE_SLOW_CYC;
      t    = fast + ((slow - fast) * div) / `PMC_DIV_MAX;
      if (t == 32'h0)
        t = 32'h1;
      wake_cycles = t[CW-1:0];
    end
  endfunction

  reg [7:0]    pmode_q;
  reg [2:0]    pllsrc_q;
  reg [2:0]    pend_q;
  reg [2:0]    seq_q;
  reg          pkey_armed_q;
  reg [31:0]   awaddr_q;
  reg          aw_held_q;
  reg [31:0]   wdata_q;
  reg [3:0]    wstrb_q;
  reg          w_held_q;
  reg [CW-1:0] div_cnt_q;
  reg          wake_slow_q;
  wire         wake_busy;
  wire         wake_done;
  wire         wr_fire;
  wire [2:0]   wsel;
  wire [15:0]  wkey;
  wire         wlane0;
  wire         wake_start;
  wire [CW-1:0] div_limit;

  // Address and data accepted independently, one write at a time
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire       = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wsel          = reg_sel(awaddr_q);
  assign wkey          = wdata_q[15:0];
  assign wlane0        = wstrb_q[0];

  // Write channel capture and response
  always @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_q     <= 32'h0;
      aw_held_q    <= 1'b0;
      wdata_q      <= 32'h0;
      wstrb_q      <= 4'h0;
      w_held_q     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PMC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q  <= s_axi_awaddr;
        aw_held_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
        w_held_q <= 1'b1;
      end
      if (wr_fire) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wsel == SEL_NONE) ? `PMC_RESP_DECERR : `PMC_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Key sequences: every bus write is one instruction, so any other write breaks a sequence.
  // Reads do not count, as they cannot disturb the settings.
  always @(posedge aclk) begin
    if (!aresetn) begin
      seq_q        <= SEQ_IDLE;
      pend_q       <= 3'h0;
      pllsrc_q     <= `PMC_PLL_SOURCE_RST;
      pkey_armed_q <= 1'b0;
    end else if (wr_fire) begin
      pkey_armed_q <= (wsel == SEL_PKEY) && wlane0 && (wkey == `PMC_POWER_KEY_VAL);
      case (seq_q)
        SEQ_IDLE: begin
          if (wsel == SEL_PLLK1 && wlane0 && wkey == `PMC_PLL_KEY1_VAL)
            seq_q <= SEQ_KEYED;
        end
        SEQ_KEYED: begin
          if (wsel == SEL_PLLSRC && wlane0) begin
            pend_q <= wdata_q[2:0];
            seq_q  <= SEQ_HELD;
          end else if (wsel == SEL_PLLK1 && wlane0 && wkey == `PMC_PLL_KEY1_VAL) begin
            seq_q <= SEQ_KEYED;
          end else begin
            seq_q <= SEQ_IDLE;
          end
        end
        SEQ_HELD: begin
          if (wsel == SEL_PLLK2 && wlane0 && wkey == `PMC_PLL_KEY2_VAL)
            pllsrc_q <= pend_q;
          if (wsel == SEL_PLLK1 && wlane0 && wkey == `PMC_PLL_KEY1_VAL)
            seq_q <= SEQ_KEYED;
          else
            seq_q <= SEQ_IDLE;
        end
        default: seq_q <= SEQ_IDLE;
      endcase
    end
  end

  // Wake only from a powered-down core; class chosen by whether the PLL kept running
  assign wake_start = wake_event && !pmode_q[`PMC_CORE_BIT] && !wake_busy;

  always @(posedge aclk) begin
    if (!aresetn)
      wake_slow_q <= 1'b0;
    else if (wake_start)
      wake_slow_q <= !pmode_q[`PMC_PLL_BIT];
  end

  pmc_wake_timer #(
    .CW    (CW)
  ) u_wake (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (wake_start),
    .count   (wake_cycles(!pmode_q[`PMC_PLL_BIT], pmode_q[2:0])),
    .busy    (wake_busy),
    .done    (wake_done)
  );

  // Power mode register; hardware wake-up set wins over a same-cycle software write
  always @(posedge aclk) begin
    if (!aresetn) begin
      pmode_q <= `PMC_POWER_MODE_RST;
    end else begin
      if (wr_fire && wsel == SEL_PMODE && wlane0 && pkey_armed_q)
        pmode_q <= {1'b0, wdata_q[6:0]};
      if (wake_done) begin
        pmode_q[`PMC_CORE_BIT]   <= 1'b1;
        pmode_q[`PMC_PERIPH_BIT] <= 1'b1;
        pmode_q[`PMC_PLL_BIT]    <= 1'b1;
      end
    end
  end

  // Domain enables follow the mode bits; interrupt lines stay alive in every mode
  always @(posedge aclk) begin
    if (!aresetn) begin
      core_run_enable          <= 1'b1;
      peripheral_run_enable    <= 1'b1;
      pll_run_enable           <= 1'b1;
      crystal_run_enable       <= 1'b1;
      external_interrupt_alive <= 1'b1;
    end else begin
      core_run_enable          <= pmode_q[`PMC_CORE_BIT];
      peripheral_run_enable    <= pmode_q[`PMC_PERIPH_BIT];
      pll_run_enable           <= pmode_q[`PMC_PLL_BIT];
      crystal_run_enable       <= pmode_q[`PMC_XTAL_BIT];
      external_interrupt_alive <= 1'b1;
    end
  end

  // PLL reference selection from the committed source register
  always @(posedge aclk) begin
    if (!aresetn) begin
      external_clock_select <= 1'b0;
      crystal_select        <= 1'b0;
      internal_osc_select   <= 1'b1;
    end else begin
      external_clock_select <= pllsrc_q[`PMC_EXT_CLK_BIT];
      crystal_select        <= !pllsrc_q[`PMC_EXT_CLK_BIT] &&
                               (pllsrc_q[1:0] == `PMC_OSC_CHOICE_XTAL);
      internal_osc_select   <= !pllsrc_q[`PMC_EXT_CLK_BIT] &&
                               (pllsrc_q[1:0] != `PMC_OSC_CHOICE_XTAL);
    end
  end

  // Core clock enable: base rate halves per divider step, stopped with the core.
  // One clock only, so the core rate is a pulse train rather than a real clock.
  assign div_limit = ({{(CW-1){1'b0}}, 1'b1} << pmode_q[2:0]) * CORE_BASE_DIV[CW-1:0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_q   <= {CW{1'b0}};
      core_clk_en <= 1'b0;
    end else if (!pmode_q[`PMC_CORE_BIT]) begin
      div_cnt_q   <= {CW{1'b0}};
      core_clk_en <= 1'b0;
    end else if (div_cnt_q >= div_limit - {{(CW-1){1'b0}}, 1'b1}) begin
      div_cnt_q   <= {CW{1'b0}};
      core_clk_en <= 1'b1;
    end else begin
      div_cnt_q   <= div_cnt_q + {{(CW-1){1'b0}}, 1'b1};
      core_clk_en <= 1'b0;
    end
  end

  // Read channel; key registers are write-only and read as zero
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `PMC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `PMC_RESP_OKAY;
      case (reg_sel(s_axi_araddr))
        SEL_PMODE:  s_axi_rdata <= {24'h0, pmode_q};
        SEL_PLLSRC: s_axi_rdata <= {29'h0, pllsrc_q};
        SEL_STAT:   s_axi_rdata <= {26'h0, seq_q[2], pmode_q[`PMC_XTAL_BIT],
                                    pmode_q[`PMC_PLL_BIT], pmode_q[`PMC_PERIPH_BIT],
                                    pmode_q[`PMC_CORE_BIT], wake_busy};
        SEL_NONE: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `PMC_RESP_DECERR;
        end
        default:    s_axi_rdata <= 32'h0;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // pmc_top

// File: verilog/pmc_consts.vh
// Overview of operation
// - The four-bit mode code keeps core, peripherals, PLL, crystal/timers running per bit.
// - Leaving pause or nap resumes after 4.8 us at the fastest divider, 660 us at the slowest.
// - Leaving sleep or stop resumes after 66 us at the fastest divider, 900 us at the slowest.
// - Bit 2 of the PLL source register selects the external clock pin, clearing it disables it.
// - Oscillator choice 10 selects the crystal, every other code the internal 32,768 Hz one.
// - The three-bit core divider gives 10.24 MHz at 000, halving per step; 011 is the default. The code pulses core_clk_en at 12.5 MHz at 000.
// - A wake-up event sets the core, peripheral and PLL enable bits again. The code acts on it only while the core enable bit is clear.
`ifndef PMC_CONSTS_VH
`define PMC_CONSTS_VH
// Byte addresses
`define PMC_ADDR_POWER_MODE   32'hffff0408
`define PMC_ADDR_POWER_KEY    32'hffff040c
`define PMC_ADDR_PLL_KEY1     32'hffff0410
`define PMC_ADDR_PLL_SOURCE   32'hffff0414
`define PMC_ADDR_PLL_KEY2     32'hffff0418
`define PMC_ADDR_STATUS       32'hffff041c
// Key values
`define PMC_POWER_KEY_VAL     16'h00f4
`define PMC_PLL_KEY1_VAL      16'h00aa
`define PMC_PLL_KEY2_VAL      16'h0055
// Power mode register fields
`define PMC_DIV_LSB           0
`define PMC_DIV_MSB           2
`define PMC_CORE_BIT          3
`define PMC_PERIPH_BIT        4
`define PMC_PLL_BIT           5
`define PMC_XTAL_BIT          6
`define PMC_POWER_MODE_RST    8'h7b
// PLL source register fields
`define PMC_OSC_CHOICE_LSB    0
`define PMC_OSC_CHOICE_MSB    1
`define PMC_EXT_CLK_BIT       2
`define PMC_OSC_CHOICE_XTAL   2'h2
`define PMC_PLL_SOURCE_RST    3'h0
// Timing
`define PMC_CLK_PERIOD_NS     40
`define PMC_PAUSE_FAST_NS     4800
`define PMC_PAUSE_SLOW_NS     660000
`define PMC_SLEEP_FAST_NS     66000
`define PMC_SLEEP_SLOW_NS     900000
`define PMC_DIV_MAX           7
// AXI responses
`define PMC_RESP_OKAY         2'h0
`define PMC_RESP_DECERR       2'h3
`endif

// File: verilog/pmc_wake_timer.v
`timescale 1ns/10ps
`include "pmc_consts.vh"
module pmc_wake_timer #(
  parameter CW = 16
) (
  input  wire          aclk,
  input  wire          aresetn,
  input  wire          start,
  input  wire [CW-1:0] count,
  output wire          busy,
  output reg           done
);
  reg [CW-1:0] cnt_q;
  reg          run_q;

  // Down counter, done pulses in the cycle after the last cycle of the wait, as busy drops
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= {CW{1'b0}};
      run_q <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !run_q) begin
        cnt_q <= count;
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q <= {{(CW-1){1'b0}}, 1'b1}) begin
          run_q <= 1'b0;
          done  <= 1'b1;
        end else begin
          cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  assign busy = run_q;
endmodule // pmc_wake_timer

// File: bench/pmc_top_props.sv
`timescale 1ns/10ps
module pmc_top_props (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awready,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        core_run_enable,
  input wire        peripheral_run_enable,
  input wire        pll_run_enable,
  input wire        external_interrupt_alive,
  input wire        core_clk_en,
  input wire        external_clock_select,
  input wire        crystal_select,
  input wire        internal_osc_select
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Read request accepted, answer one cycle later
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_read_answer: assert property (s_ar_take |=> s_axi_rvalid)
    else $error("read answer missing");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  chk_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  chk_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during answer");
  // Exactly one clock source reaches the PLL at any time
  chk_source_onehot: assert property ($onehot({external_clock_select,
    crystal_select, internal_osc_select})) else $error("pll source not one-hot");
  chk_irq_alive: assert property (external_interrupt_alive)
    else $error("interrupt lines not alive");
  chk_core_gate: assert property (!core_run_enable [*2] |-> !core_clk_en)
    else $error("core clock runs while core stopped");
  chk_wake_together: assert property ($rose(core_run_enable) |->
    peripheral_run_enable && pll_run_enable) else $error("wake sets bits apart");
endmodule // pmc_top_props

bind pmc_top pmc_top_props u_chk (.*);

// File: bench/tb_pmc_top.sv
`timescale 1ns/10ps
`include "pmc_consts.vh"
module tb_pmc_top;
  localparam PF = 4, PS = 20, SF = 10, SS = 30;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, wake_event, core_run_enable, peripheral_run_enable;
  logic pll_run_enable, crystal_run_enable, external_interrupt_alive, core_clk_en;
  logic external_clock_select, crystal_select, internal_osc_select;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  modes [4] = '{8'h70, 8'h60, 8'h40, 8'h00};
  logic [7:0]  v;
  int n_mismatch = 0, comparisons = 0, n, e;

  // Short wake counts keep the run brief
  pmc_top #(.PAUSE_FAST_CYC(PF), .PAUSE_SLOW_CYC(PS), .SLEEP_FAST_CYC(SF),
    .SLEEP_SLOW_CYC(SS)) dut (.*);

  always #20 aclk = ~aclk;

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    comparisons++;
    if (got !== ex) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // Write: address and data offered together, bready held until bvalid
  task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    chk("bvalid", 1'b1, s_axi_bvalid);
    chk("bresp", er, s_axi_bresp);
  endtask

  task automatic axr(input logic [31:0] a, input logic [31:0] ex, input logic [1:0] er);
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    chk("rvalid", 1'b1, s_axi_rvalid);
    chk("rresp", er, s_axi_rresp);
    chk("rdata", ex, s_axi_rdata);
  endtask

  // Full keyed update of the PLL source; k2 lets a test spoil the closing key
  task automatic pll_set(input logic [7:0] d, input logic [15:0] k2);
    axw(`PMC_ADDR_PLL_KEY1, `PMC_PLL_KEY1_VAL, `PMC_RESP_OKAY);
    axw(`PMC_ADDR_PLL_SOURCE, d, `PMC_RESP_OKAY);
    axw(`PMC_ADDR_PLL_KEY2, k2, `PMC_RESP_OKAY);
    repeat (2) @(posedge aclk);
  endtask

  task end_sim;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog far beyond the expected few hundred cycles
  initial begin
    #(40 * 20000);
    n_mismatch++;
    end_sim;
  end

  initial begin
    aclk = 0; aresetn = 0; wake_event = 0; s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axr(`PMC_ADDR_PLL_SOURCE, 32'h0, `PMC_RESP_OKAY);
    axr(`PMC_ADDR_POWER_MODE, 32'h7b, `PMC_RESP_OKAY);
    axr(`PMC_ADDR_STATUS, 32'h1e, `PMC_RESP_OKAY);
    chk("int osc", 1'b1, internal_osc_select);
    // Default divider: one core pulse every 16 cycles
    n = 0;
    repeat (64) begin
      @(posedge aclk);
      if (core_clk_en === 1'b1)
        n++;
    end
    chk("core clk pulses", 4, n);
    axr(32'hffff0500, 32'h0, `PMC_RESP_DECERR);
    axw(32'hffff0500, 32'h0, `PMC_RESP_DECERR);
    // Mode write without the power key must be ignored
    axw(`PMC_ADDR_POWER_MODE, 32'h70, `PMC_RESP_OKAY);
    axr(`PMC_ADDR_POWER_MODE, 32'h7b, `PMC_RESP_OKAY);
    axw(`PMC_ADDR_PLL_SOURCE, 32'h6, `PMC_RESP_OKAY);
    axr(`PMC_ADDR_PLL_SOURCE, 32'h0, `PMC_RESP_OKAY);
    pll_set(8'h06, `PMC_PLL_KEY2_VAL);
    chk("ext clk", 1'b1, external_clock_select);
    chk("xtal", 1'b0, crystal_select);
    pll_set(8'h02, `PMC_PLL_KEY2_VAL);
    chk("xtal", 1'b1, crystal_select);
    chk("ext clk", 1'b0, external_clock_select);
    pll_set(8'h01, 16'h0054);
    axr(`PMC_ADDR_PLL_SOURCE, 32'h2, `PMC_RESP_OKAY);
    // Held source write shows in status; an unrelated write then aborts it
    axw(`PMC_ADDR_PLL_KEY1, `PMC_PLL_KEY1_VAL, `PMC_RESP_OKAY);
    axw(`PMC_ADDR_PLL_SOURCE, 32'h1, `PMC_RESP_OKAY);
    axr(`PMC_ADDR_STATUS, 32'h3e, `PMC_RESP_OKAY);
    axw(`PMC_ADDR_POWER_KEY, `PMC_POWER_KEY_VAL, `PMC_RESP_OKAY);
    axw(`PMC_ADDR_PLL_KEY2, `PMC_PLL_KEY2_VAL, `PMC_RESP_OKAY);
    axr(`PMC_ADDR_PLL_SOURCE, 32'h2, `PMC_RESP_OKAY);
    for (int c = 0; c < 4; c = c + 2) begin
      pll_set(8'(c + 1), `PMC_PLL_KEY2_VAL);
      chk("int osc", 1'b1, internal_osc_select);
    end
    // Each low-power mode at both divider extremes, then a wake-up
    for (int i = 0; i < 8; i++) begin
      v = modes[i % 4] | ((i < 4) ? 8'h0 : 8'h7);
      axw(`PMC_ADDR_POWER_KEY, `PMC_POWER_KEY_VAL, `PMC_RESP_OKAY);
      axw(`PMC_ADDR_POWER_MODE, v, `PMC_RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("enables", v[6:3], {crystal_run_enable, pll_run_enable,
        peripheral_run_enable, core_run_enable});
      e = v[5] ? PF + ((PS - PF) * v[2:0]) / 7 : SF + ((SS - SF) * v[2:0]) / 7;
      @(posedge aclk) wake_event <= 1'b1;
      @(posedge aclk) wake_event <= 1'b0;
      n = 1;
      while (core_run_enable !== 1'b1 && n < 200) begin
        @(posedge aclk);
        n++;
      end
      chk("wake time", 1'b1, n >= e && n <= e + 4);
      axr(`PMC_ADDR_POWER_MODE, v | 8'h38, `PMC_RESP_OKAY);
    end
    end_sim;
  end
endmodule // tb_pmc_top
